/* logic/ist_pkg.sv */
// instruction state timing: shared widths, per-cycle state figures, types
// assumes one system clock; the cpu supplies instruction class and targets
package ist_pkg;
  localparam int CNT_W = 2; // cycles of one category per instruction
  localparam int SPC_W = 8; // states taken by one cycle
  localparam int TOTAL_W = 12; // states of a whole instruction
  localparam int WAIT_W = 4; // wait states m on three-state external accesses
  // states of one cycle, before doubling for a word over an 8-bit bus
  localparam logic [SPC_W-1:0] S_ONCHIP = 8'h02;
  localparam logic [SPC_W-1:0] S_MODULE = 8'h03;
  localparam logic [SPC_W-1:0] S_EXT_2ST = 8'h02;
  localparam logic [SPC_W-1:0] S_EXT_3ST = 8'h03;
  localparam logic [SPC_W-1:0] S_INTERNAL = 8'h01;
  localparam logic [CNT_W-1:0] C_ZERO = 2'h0;
  localparam logic [CNT_W-1:0] C_ONE = 2'h1;
  localparam logic [CNT_W-1:0] C_TWO = 2'h2;
  localparam logic [CNT_W-1:0] C_THREE = 2'h3;

  // where a cycle goes
  typedef enum logic [2:0] {
    IST_TGT_ONCHIP = 3'h0,
    IST_TGT_MOD8 = 3'h1,
    IST_TGT_MOD16 = 3'h2,
    IST_TGT_EXT8_2ST = 3'h3,
    IST_TGT_EXT8_3ST = 3'h4,
    IST_TGT_EXT16_2ST = 3'h5,
    IST_TGT_EXT16_3ST = 3'h6
  } ist_target_t;

  // instruction classes with known cycle counts
  typedef enum logic [3:0] {
    IST_OP_ADD_B_IMM = 4'h0,
    IST_OP_ADD_REG = 4'h1,
    IST_OP_ADD_W_IMM = 4'h2,
    IST_OP_ADD_L_IMM = 4'h3,
    IST_OP_ADD_SMALL = 4'h4,
    IST_OP_ADD_CARRY = 4'h5,
    IST_OP_AND_B_IMM = 4'h6,
    IST_OP_AND_REG_BW = 4'h7,
    IST_OP_AND_W_IMM = 4'h8,
    IST_OP_AND_L_IMM = 4'h9,
    IST_OP_AND_L_REG = 4'ha,
    IST_OP_AND_FLAGS = 4'hb,
    IST_OP_BIT_AND_REG = 4'hc,
    IST_OP_BIT_AND_MEM = 4'hd,
    IST_OP_BRANCH8 = 4'he
  } ist_instr_t;

  typedef struct packed {
    logic [CNT_W-1:0] fetch;
    logic [CNT_W-1:0] br_read;
    logic [CNT_W-1:0] stack;
    logic [CNT_W-1:0] byte_acc;
    logic [CNT_W-1:0] word_acc;
    logic [CNT_W-1:0] internal;
  } ist_cycles_t;

  typedef struct packed {
    logic [SPC_W-1:0] fetch;
    logic [SPC_W-1:0] br_read;
    logic [SPC_W-1:0] stack;
    logic [SPC_W-1:0] byte_acc;
    logic [SPC_W-1:0] word_acc;
    logic [SPC_W-1:0] internal;
  } ist_spc_t;

  typedef struct packed {
    ist_instr_t instr;
    ist_target_t fetch_tgt;
    ist_target_t branch_tgt;
    ist_target_t stack_tgt;
    ist_target_t data_tgt;
    logic [WAIT_W-1:0] wait_states;
  } ist_req_t;

  typedef enum logic [1:0] {
    IST_IDLE = 2'b01,
    IST_RUN = 2'b10
  } ist_state_t;
endpackage

/* logic/ist_timer.sv */
// instruction state timer: works out the states an instruction takes and
// then counts them off, pulsing done at the end
// assumes start and req are synchronous to clock; start is ignored while busy
`timescale 1ns/100ps
module ist_timer (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic start,
  input wire ist_pkg::ist_req_t req,
  output logic busy,
  output logic done,
  output logic [ist_pkg::TOTAL_W-1:0] total,
  output ist_pkg::ist_cycles_t cycles,
  output ist_pkg::ist_spc_t spc
);
  // states per cycle for one target; word doubles on 8-bit paths
  function automatic logic [ist_pkg::SPC_W-1:0] states_of(input ist_pkg::ist_target_t tgt,
      input logic is_word, input logic [ist_pkg::WAIT_W-1:0] m);
    logic [ist_pkg::SPC_W-1:0] base;
    logic narrow;
    base = ist_pkg::S_ONCHIP;
    narrow = 1'b0;
    unique case (tgt)
      ist_pkg::IST_TGT_ONCHIP: base = ist_pkg::S_ONCHIP;
      ist_pkg::IST_TGT_MOD8: begin
        base = ist_pkg::S_MODULE;
        narrow = 1'b1;
      end
      ist_pkg::IST_TGT_MOD16: base = ist_pkg::S_MODULE;
      ist_pkg::IST_TGT_EXT8_2ST: begin
        base = ist_pkg::S_EXT_2ST;
        narrow = 1'b1;
      end
      ist_pkg::IST_TGT_EXT8_3ST: begin
        base = ist_pkg::S_EXT_3ST + ist_pkg::SPC_W'(m);
        narrow = 1'b1;
      end
      ist_pkg::IST_TGT_EXT16_2ST: base = ist_pkg::S_EXT_2ST;
      ist_pkg::IST_TGT_EXT16_3ST: base = ist_pkg::S_EXT_3ST + ist_pkg::SPC_W'(m);
      default: base = ist_pkg::S_ONCHIP; // unused target code
    endcase
    return (is_word && narrow) ? ist_pkg::SPC_W'(base << 1) : base;
  endfunction

  // cycle counts for each instruction class
  function automatic ist_pkg::ist_cycles_t cycles_of(input ist_pkg::ist_instr_t op);
    ist_pkg::ist_cycles_t c;
    c = '0;
    unique case (op)
      ist_pkg::IST_OP_ADD_W_IMM, ist_pkg::IST_OP_AND_W_IMM,
      ist_pkg::IST_OP_AND_L_REG: c.fetch = ist_pkg::C_TWO;
      ist_pkg::IST_OP_ADD_L_IMM, ist_pkg::IST_OP_AND_L_IMM: c.fetch = ist_pkg::C_THREE;
      ist_pkg::IST_OP_BIT_AND_MEM: begin
        c.fetch = ist_pkg::C_TWO;
        c.byte_acc = ist_pkg::C_ONE;
      end
      ist_pkg::IST_OP_BRANCH8: c.fetch = ist_pkg::C_TWO;
      ist_pkg::IST_OP_BIT_AND_REG: c.fetch = ist_pkg::C_ONE;
      default: c.fetch = ist_pkg::C_ONE;
    endcase
    return c;
  endfunction

  // one category's share of the total
  function automatic logic [ist_pkg::TOTAL_W-1:0] term(input logic [ist_pkg::CNT_W-1:0] n,
      input logic [ist_pkg::SPC_W-1:0] s);
    return ist_pkg::TOTAL_W'(n) * ist_pkg::TOTAL_W'(s);
  endfunction

  ist_pkg::ist_state_t state_q, state_d; // sequencer
  logic [ist_pkg::TOTAL_W-1:0] remain_q, remain_d; // states still to run
  logic [ist_pkg::TOTAL_W-1:0] total_q; // latched total
  logic done_q; // end pulse
  logic busy_q; // counting
  ist_pkg::ist_cycles_t cycles_q; // latched counts
  ist_pkg::ist_spc_t spc_q; // latched states per cycle
  ist_pkg::ist_req_t req_q; // latched request

  // per-category figures for the incoming request
  wire accept = start && (state_q == ist_pkg::IST_IDLE);
  wire last = (state_q == ist_pkg::IST_RUN) && (remain_q == ist_pkg::TOTAL_W'(1));
  ist_pkg::ist_cycles_t cyc_w;
  ist_pkg::ist_spc_t spc_w;
  logic [ist_pkg::TOTAL_W-1:0] total_w;
  assign cyc_w = cycles_of(req.instr);
  assign spc_w.fetch = states_of(req.fetch_tgt, 1'b1, req.wait_states);
  assign spc_w.br_read = states_of(req.branch_tgt, 1'b1, req.wait_states);
  assign spc_w.stack = states_of(req.stack_tgt, 1'b1, req.wait_states);
  assign spc_w.byte_acc = states_of(req.data_tgt, 1'b0, req.wait_states);
  assign spc_w.word_acc = states_of(req.data_tgt, 1'b1, req.wait_states);
  assign spc_w.internal = ist_pkg::S_INTERNAL;
  // weighted sum over the six categories
  assign total_w = term(cyc_w.fetch, spc_w.fetch) + term(cyc_w.br_read, spc_w.br_read)
      + term(cyc_w.stack, spc_w.stack) + term(cyc_w.byte_acc, spc_w.byte_acc)
      + term(cyc_w.word_acc, spc_w.word_acc) + term(cyc_w.internal, spc_w.internal);

  // next state and countdown
  always_comb begin
    state_d = state_q;
    remain_d = remain_q;
    unique case (state_q)
      ist_pkg::IST_IDLE: if (start) begin
        state_d = ist_pkg::IST_RUN;
        remain_d = total_w;
      end
      ist_pkg::IST_RUN: begin
        remain_d = remain_q - ist_pkg::TOTAL_W'(1);
        if (last) begin
          state_d = ist_pkg::IST_IDLE;
        end
      end
      default: state_d = ist_pkg::IST_IDLE; // illegal code recovers
    endcase
  end

  // sequencer registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ist_pkg::IST_IDLE;
      remain_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      remain_q <= remain_d;
      busy_q <= (state_d == ist_pkg::IST_RUN);
      done_q <= last;
    end
  end

  // figures latched on acceptance
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      total_q <= '0;
      cycles_q <= '0;
      spc_q <= '0;
      req_q <= '0;
    end else if (accept) begin
      total_q <= total_w;
      cycles_q <= cyc_w;
      spc_q <= spc_w;
      req_q <= req;
    end
  end

  assign busy = busy_q;
  assign done = done_q;
  assign total = total_q;
  assign cycles = cycles_q;
  assign spc = spc_q;

  // run length counter, read only by the checks
  logic [ist_pkg::TOTAL_W-1:0] elapsed_q;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      elapsed_q <= '0;
    end else if (accept) begin
      elapsed_q <= '0;
    end else if (state_q == ist_pkg::IST_RUN) begin
      elapsed_q <= elapsed_q + ist_pkg::TOTAL_W'(1);
    end
  end

  // checks share the system clock and sleep while reset is low
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  // request taken while idle
  sequence s_accept;
    start && (state_q == ist_pkg::IST_IDLE);
  endsequence
  // counting, end pulse not yet given
  sequence s_running;
    busy_q && !done_q;
  endsequence

  // end pulse comes after exactly the latched number of states
  a_done_length: assert property (done_q |-> elapsed_q == total_q && total_q != '0)
    else $error("done does not match total states");
  a_start_busy: assert property (s_accept |=> s_running)
    else $error("accepted request not running");
  // states per cycle for the latched targets
  a_onchip_internal: assert property (busy_q |-> spc_q.internal == 8'h01 &&
      (req_q.fetch_tgt != ist_pkg::IST_TGT_ONCHIP || spc_q.fetch == 8'h02))
    else $error("on-chip or internal states wrong");
  a_ext16_wait: assert property (busy_q && req_q.fetch_tgt == ist_pkg::IST_TGT_EXT16_3ST
      |-> spc_q.fetch == 8'h03 + 8'(req_q.wait_states))
    else $error("16-bit three-state fetch wrong");
  a_ext8_three: assert property (busy_q && req_q.data_tgt == ist_pkg::IST_TGT_EXT8_3ST
      |-> spc_q.byte_acc == 8'h03 + 8'(req_q.wait_states) &&
      spc_q.word_acc == 8'h06 + 8'({req_q.wait_states, 1'b0}))
    else $error("8-bit three-state data wrong");
  a_ext8_two: assert property (busy_q && req_q.data_tgt == ist_pkg::IST_TGT_EXT8_2ST
      |-> spc_q.byte_acc == 8'h02 && spc_q.word_acc == 8'h04)
    else $error("8-bit two-state data wrong");
  a_module_bus: assert property (busy_q && req_q.data_tgt == ist_pkg::IST_TGT_MOD8
      |-> spc_q.byte_acc == 8'h03 && spc_q.word_acc == 8'h06)
    else $error("8-bit module data wrong");
  // cycle counts of the class just taken
  a_simple_fetch: assert property (s_accept ##0 (req.instr == ist_pkg::IST_OP_ADD_SMALL ||
      req.instr == ist_pkg::IST_OP_AND_FLAGS || req.instr == ist_pkg::IST_OP_ADD_REG)
      |=> cycles_q.fetch == 2'h1 && total_q == 12'(spc_q.fetch))
    else $error("single fetch instruction wrong");
  a_bit_mem: assert property (s_accept ##0 req.instr == ist_pkg::IST_OP_BIT_AND_MEM
      |=> cycles_q.fetch == 2'h2 && cycles_q.byte_acc == 2'h1 &&
      total_q == 12'({spc_q.fetch, 1'b0}) + 12'(spc_q.byte_acc))
    else $error("bit-and memory form wrong");
  a_branch_two: assert property (s_accept ##0 req.instr == ist_pkg::IST_OP_BRANCH8
      |=> cycles_q == ist_pkg::ist_cycles_t'({2'h2, 10'h000}))
    else $error("short branch cycles wrong");
endmodule

/* verif/ist_bus_model.sv */
// bus side model: maps an address region to the access condition found there
// assumes regions 0 to 6 follow the target encoding of the package
`timescale 1ns/100ps
module ist_bus_model (
  input wire logic [2:0] region,
  output ist_pkg::ist_target_t tgt
);
  // region 7 has no device behind it, so it reads as on-chip memory
  assign tgt = (region == 3'h7) ? ist_pkg::IST_TGT_ONCHIP : ist_pkg::ist_target_t'(region);
endmodule

/* verif/test_ist_timer.sv */
// testbench for the instruction state timer: cycle counts and state totals
// assumes the package is compiled first and the bus model sits beside it
`timescale 1ns/100ps
module test_ist_timer;
  logic clock = 1'b0; // system clock
  logic arst_n = 1'b0; // async reset
  logic start = 1'b0; // request strobe
  ist_pkg::ist_req_t req = '0; // request fields
  logic [2:0] region = 3'h0; // bus model region
  ist_pkg::ist_target_t tgt; // access condition of region
  logic busy; // counting
  logic done; // end pulse
  logic [ist_pkg::TOTAL_W-1:0] total; // states of instruction
  ist_pkg::ist_cycles_t cycles; // cycle counts
  ist_pkg::ist_spc_t spc; // states per cycle
  int errors = 0; // mismatches
  int cmp_count = 0; // comparisons
  // clock of 40 ns period
  always #20 clock = ~clock;
  ist_timer dut_u (.clock(clock), .arst_n(arst_n), .start(start), .req(req), .busy(busy), .done(done),
    .total(total), .cycles(cycles), .spc(spc));
  ist_bus_model bus_u (.region(region), .tgt(tgt));
  // compare and report
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // closing line and verdict
  task automatic print_verdict();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // fetch states per target
  function automatic int sf(input int t, input int m);
    case (t)
      1: sf = 6;
      2: sf = 3;
      3: sf = 4;
      4: sf = 6 + 2 * m;
      5: sf = 2;
      6: sf = 3 + m;
      default: sf = 2;
    endcase
  endfunction
  // byte access states per target
  function automatic int sb(input int t, input int m);
    case (t)
      1, 2: sb = 3;
      4, 6: sb = 3 + m;
      default: sb = 2;
    endcase
  endfunction
  // one instruction; entered just after an edge, returns just after done edge
  task automatic run(input ist_pkg::ist_instr_t ins, input logic [3:0] m, input int ei, input int et,
    input bit poke);
    int n;
    n = 0;
    start = 1'b1;
    req.instr = ins;
    req.fetch_tgt = tgt;
    req.data_tgt = tgt;
    req.wait_states = m;
    @(posedge clock);
    #1;
    start = 1'b0;
    chk(total, et[15:0]);
    chk(cycles.fetch, ei[15:0]);
    chk(spc.internal, 16'h1);
    chk(busy, 16'h1);
    // wait for done, optionally retrying start while busy
    while (done !== 1'b1 && n < 700) begin
      if (poke && n == 2) begin
        start = 1'b1;
        req.instr = ist_pkg::IST_OP_ADD_L_IMM;
      end else begin
        start = 1'b0;
      end
      @(posedge clock);
      #1;
      n++;
    end
    chk(n[15:0], et[15:0]);
    chk(total, et[15:0]);
    chk(busy, 16'h0);
    chk(done, 16'h1);
  endtask
  // short branch on chip, refused start, then back to back long immediate
  task automatic s_walk();
    region = 3'h0;
    @(posedge clock);
    #1;
    run(ist_pkg::IST_OP_BRANCH8, 4'h0, 2, 4, 1'b1);
    chk(cycles.byte_acc, 16'h0);
    run(ist_pkg::IST_OP_ADD_L_IMM, 4'h0, 3, 6, 1'b0);
  endtask
  // every instruction class on chip
  task automatic s_instr();
    int i;
    int mem;
    int fc [15] = '{1, 1, 2, 3, 1, 1, 1, 1, 2, 3, 2, 1, 1, 2, 2};
    for (int k = 0; k < 15; k++) begin
      mem = (k == 13) ? 1 : 0;
      i = fc[k];
      @(posedge clock);
      #1;
      run(ist_pkg::ist_instr_t'(k), 4'h0, i, 2 * i + 2 * mem, 1'b0);
      chk(cycles.byte_acc, mem[15:0]);
    end
  endtask
  // memory bit instruction over every target, with and without waits
  task automatic s_targets();
    int w;
    for (int t = 0; t < 7; t++) begin
      for (int j = 0; j < 2; j++) begin
        w = 5 * j;
        region = t[2:0];
        @(posedge clock);
        #1;
        run(ist_pkg::IST_OP_BIT_AND_MEM, w[3:0], 2, 2 * sf(t, w) + sb(t, w), 1'b0);
        chk(spc.byte_acc, 16'(sb(t, w)));
        chk(spc.fetch, 16'(sf(t, w)));
      end
    end
    region = 3'h4;
    @(posedge clock);
    #1;
    run(ist_pkg::IST_OP_ADD_L_IMM, 4'hf, 3, 108, 1'b0);
    region = 3'h3;
    @(posedge clock);
    #1;
    run(ist_pkg::IST_OP_AND_W_IMM, 4'h9, 2, 8, 1'b0);
  endtask
  // level start held while counting is refused, then reset cuts the count short
  task automatic s_reset();
    region = 3'h4;
    @(posedge clock);
    #1;
    start = 1'b1;
    req.instr = ist_pkg::IST_OP_ADD_L_IMM;
    req.fetch_tgt = tgt;
    req.data_tgt = tgt;
    req.wait_states = 4'hf;
    repeat (3) @(posedge clock);
    #1;
    start = 1'b0;
    chk(total, 16'h6c);
    chk(busy, 16'h1);
    arst_n = 1'b0;
    #1;
    chk(busy, 16'h0);
    chk(total, 16'h0);
    chk(cycles, 16'h0);
    @(posedge clock);
    #1;
    arst_n = 1'b1;
    run(ist_pkg::IST_OP_ADD_REG, 4'h2, 1, 10, 1'b0);
  endtask
  // watchdog cuts a hang short
  initial begin
    #(40 * 20000);
    errors++;
    print_verdict();
  end
  // main sequence
  initial begin
    repeat (6) @(posedge clock);
    #1;
    arst_n = 1'b1;
    chk(total, 16'h0);
    chk(busy, 16'h0);
    chk(done, 16'h0);
    s_walk();
    s_instr();
    s_targets();
    s_reset();
    print_verdict();
  end
endmodule
